// [design/bpu_pkg.sv]
// package for the branch predictor unit: widths, table sizes, branch kinds, timing constants
// assumes a single 20 MHz core clock and a 32-bit linear address space
package bpu_pkg;

  // ==========================================================================
  // sizes
  localparam int ADDR_W = 32;
  localparam int THT_ENTRIES = 64;
  localparam int THT_IDX_W = 6;
  localparam int THT_TAG_W = ADDR_W - THT_IDX_W - 2;
  localparam int RAS_DEPTH = 16;
  localparam int RAS_PTR_W = 4;
  localparam int CHUNK_BYTES = 32;
  localparam int CHUNK_LSB = 5;
  localparam int CTR_W = 2;

  // ==========================================================================
  // reset values and fixed figures
  localparam logic [CTR_W-1:0] CTR_WEAK_TAKEN = 2'h2;
  localparam logic [CTR_W-1:0] CTR_MAX = 2'h3;
  localparam logic [CTR_W-1:0] CTR_MIN = 2'h0;
  localparam logic [RAS_PTR_W-1:0] RAS_PTR_RST = 4'h0;
  localparam logic [4:0] RAS_CNT_RST = 5'h00;
  localparam logic [4:0] RAS_CNT_MAX = 5'h10;
  localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;
  localparam int CALL_LEN_W = 4;
  // recovery delay roughly equals pipeline depth
  localparam int PIPE_DEPTH = 20;
  localparam logic [4:0] RECOVER_CYCLES = 5'(PIPE_DEPTH);

  // ==========================================================================
  // branch kinds presented by decode and retirement
  typedef enum logic [2:0] {
    BK_NONE = 3'h0,
    BK_COND = 3'h1,
    BK_CALL = 3'h2,
    BK_RET = 3'h3,
    BK_IND = 3'h4,
    BK_FAR = 3'h5
  } bpu_kind_t;

  // ==========================================================================
  // fetch steering state
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RECOVER = 2'b10
  } bpu_state_t;

endpackage

// [design/bpu_top.sv]
// branch predictor unit: target/history table, static fallback, return stack, fetch steering
// assumes fetch, decode and retirement sit in the same core_clk domain and drive one request each
`timescale 1ns/100ps

// What this block does
// - predict only near transfers: conditional, call, return and indirect branches
// - far calls, interrupt returns and software interrupts get no predicted target
// - direction and target looked up in the table by linear address
// - table hit gives a prediction at fetch, before the instruction is decoded
// - after decode with no valid table entry, static predictor uses direction
// - static: conditional with negative displacement predicted taken, forward predicted not taken; other near kinds taken
// - returns always taken at decode, at fetch only with the stack not empty; target popped from a sixteen entry return stack
// - table written with the resolved target only when the branch retires
// - a correct prediction redirects fetch the same cycle, no bubble
// - a misprediction stalls fetch for about the pipeline depth
// - predicted taken branches flag trace continuation into the target
// - fetch walks the predicted path in 32-byte chunks from the target
module bpu_top
  import bpu_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // fetch side
  input wire logic fetch_ready,
  output logic fetch_valid_q,
  output logic [ADDR_W-1:0] fetch_addr_q,
  output logic fetch_pred_taken_q,
  output logic trace_continue_q,
  // decode side
  input wire logic dec_valid,
  input wire logic [ADDR_W-1:0] dec_pc,
  input wire bpu_kind_t dec_kind,
  input wire logic [ADDR_W-1:0] dec_disp,
  input wire logic [CALL_LEN_W-1:0] dec_len,
  output logic dec_pred_taken_q,
  output logic [ADDR_W-1:0] dec_pred_target_q,
  output logic dec_pred_static_q,
  // retirement side
  input wire logic ret_valid,
  input wire logic [ADDR_W-1:0] ret_pc,
  input wire bpu_kind_t ret_kind,
  input wire logic ret_taken,
  input wire logic [ADDR_W-1:0] ret_target,
  input wire logic ret_mispredict,
  output logic recover_busy_q
);

  // ==========================================================================
  // target/history table storage
  // direct mapped: two branches that share an index evict each other
  logic tht_valid_q [THT_ENTRIES];
  logic [THT_TAG_W-1:0] tht_tag_q [THT_ENTRIES];
  logic [ADDR_W-1:0] tht_target_q [THT_ENTRIES];
  logic [CTR_W-1:0] tht_ctr_q [THT_ENTRIES];
  logic tht_near_q [THT_ENTRIES];
  logic tht_ret_q [THT_ENTRIES];
  logic tht_call_q [THT_ENTRIES];

  // ==========================================================================
  // return stack, speculative and retired copies
  // the retired copy lets a mispredict rewind pushes and pops made on the wrong path
  logic [ADDR_W-1:0] ras_q [RAS_DEPTH];
  logic [RAS_PTR_W-1:0] ras_top_q;
  logic [4:0] ras_cnt_q;
  logic [RAS_PTR_W-1:0] ras_top_arch_q;
  logic [4:0] ras_cnt_arch_q;
  logic [ADDR_W-1:0] ras_arch_q [RAS_DEPTH];

  bpu_state_t state_q;
  logic [4:0] recover_cnt_q;
  logic [ADDR_W-1:0] redirect_q;

  // ==========================================================================
  // fetch-time lookup
  logic [THT_IDX_W-1:0] f_idx;
  logic [THT_TAG_W-1:0] f_tag;
  logic f_hit;
  logic f_taken;
  logic f_is_ret;
  logic f_is_call;
  logic [ADDR_W-1:0] f_target;
  logic [ADDR_W-1:0] f_seq;
  logic [ADDR_W-1:0] ras_top_val;
  logic ras_nonempty;

  assign f_idx = fetch_addr_q[THT_IDX_W+1:2];
  assign f_tag = fetch_addr_q[ADDR_W-1:THT_IDX_W+2];
  assign f_hit = tht_valid_q[f_idx] && tht_tag_q[f_idx] == f_tag && tht_near_q[f_idx];
  assign f_is_ret = f_hit && tht_ret_q[f_idx];
  assign f_is_call = f_hit && tht_call_q[f_idx] && tht_ctr_q[f_idx][CTR_W-1];
  assign ras_nonempty = ras_cnt_q != RAS_CNT_RST;
  assign ras_top_val = ras_q[ras_top_q - 4'h1];
  // returns are always taken when the stack has an address
  assign f_taken = f_is_ret ? ras_nonempty : (f_hit && tht_ctr_q[f_idx][CTR_W-1]);
  assign f_target = f_is_ret ? ras_top_val : tht_target_q[f_idx];
  // sequential fetch moves to the next aligned chunk
  assign f_seq = {fetch_addr_q[ADDR_W-1:CHUNK_LSB] + 27'h1, 5'h00};

  logic fetch_step;
  assign fetch_step = fetch_valid_q && fetch_ready && state_q == ST_RUN;

  // ==========================================================================
  // fetch steering and misprediction recovery
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_RUN;
      recover_cnt_q <= 5'h00;
      redirect_q <= RESET_PC;
      fetch_valid_q <= 1'b1;
      fetch_addr_q <= RESET_PC;
      fetch_pred_taken_q <= 1'b0;
      trace_continue_q <= 1'b0;
      recover_busy_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RUN: begin
          // a mispredict outranks a fetch step in the same cycle
          if (ret_valid && ret_mispredict) begin
            state_q <= ST_RECOVER;
            recover_cnt_q <= RECOVER_CYCLES;
            redirect_q <= ret_taken ? ret_target : ret_pc + 32'h4;
            fetch_valid_q <= 1'b0;
            recover_busy_q <= 1'b1;
            trace_continue_q <= 1'b0;
            fetch_pred_taken_q <= 1'b0;
          end else if (fetch_step) begin
            // predicted target taken the same cycle; no bubble
            fetch_addr_q <= f_taken ? f_target : f_seq;
            fetch_pred_taken_q <= f_taken;
            trace_continue_q <= f_taken;
          end
        end
        ST_RECOVER: begin
          // later mispredicts are ignored here; the oldest one already owns the redirect
          if (recover_cnt_q == 5'h01) begin
            state_q <= ST_RUN;
            fetch_valid_q <= 1'b1;
            fetch_addr_q <= redirect_q;
            recover_busy_q <= 1'b0;
          end
          recover_cnt_q <= recover_cnt_q - 5'h01;
        end
        default: begin
          state_q <= ST_RUN;
          fetch_valid_q <= 1'b1;
          recover_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // decode-time prediction with static fallback
  logic [THT_IDX_W-1:0] d_idx;
  logic d_hit;
  logic d_near;
  assign d_idx = dec_pc[THT_IDX_W+1:2];
  // no near check needed: far retirements never allocate an entry
  assign d_hit = tht_valid_q[d_idx] && tht_tag_q[d_idx] == dec_pc[ADDR_W-1:THT_IDX_W+2];
  assign d_near = dec_kind inside {BK_COND, BK_CALL, BK_RET, BK_IND};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dec_pred_taken_q <= 1'b0;
      dec_pred_target_q <= RESET_PC;
      dec_pred_static_q <= 1'b0;
    end else if (!dec_valid || !d_near) begin
      // far transfers and non-branches carry no prediction
      dec_pred_taken_q <= 1'b0;
      dec_pred_target_q <= RESET_PC;
      dec_pred_static_q <= 1'b0;
    end else if (dec_kind == BK_RET) begin
      dec_pred_taken_q <= 1'b1;
      dec_pred_target_q <= ras_top_val;
      dec_pred_static_q <= 1'b0;
    end else if (d_hit) begin
      dec_pred_taken_q <= tht_ctr_q[d_idx][CTR_W-1];
      dec_pred_target_q <= tht_target_q[d_idx];
      dec_pred_static_q <= 1'b0;
    end else begin
      // unconditional near transfers are taken; conditionals follow displacement sign
      dec_pred_taken_q <= (dec_kind != BK_COND) || dec_disp[ADDR_W-1];
      dec_pred_target_q <= dec_pc + dec_disp;
      dec_pred_static_q <= 1'b1;
    end
  end

  // ==========================================================================
  // retirement update of the table
  logic [THT_IDX_W-1:0] r_idx;
  logic r_near;
  assign r_idx = ret_pc[THT_IDX_W+1:2];
  assign r_near = ret_kind inside {BK_COND, BK_CALL, BK_RET, BK_IND};

  generate
    for (genvar i = 0; i < THT_ENTRIES; i++) begin : g_tht
      logic r_sel;
      logic r_same;
      assign r_sel = ret_valid && r_near && r_idx == THT_IDX_W'(i);
      assign r_same = tht_valid_q[i] && tht_tag_q[i] == ret_pc[ADDR_W-1:THT_IDX_W+2];
      always_ff @(posedge core_clk) begin
        if (rst) begin
          tht_valid_q[i] <= 1'b0;
          tht_tag_q[i] <= '0;
          tht_target_q[i] <= RESET_PC;
          tht_ctr_q[i] <= CTR_WEAK_TAKEN;
          tht_near_q[i] <= 1'b0;
          tht_ret_q[i] <= 1'b0;
          tht_call_q[i] <= 1'b0;
        end else if (r_sel) begin
          tht_valid_q[i] <= 1'b1;
          tht_tag_q[i] <= ret_pc[ADDR_W-1:THT_IDX_W+2];
          tht_near_q[i] <= 1'b1;
          tht_ret_q[i] <= ret_kind == BK_RET;
          tht_call_q[i] <= ret_kind == BK_CALL;
          if (ret_taken) begin
            tht_target_q[i] <= ret_target;
          end
          // a new entry starts saturated toward its first outcome
          if (!r_same) begin
            tht_ctr_q[i] <= ret_taken ? CTR_MAX : CTR_MIN;
          end else if (ret_taken && tht_ctr_q[i] != CTR_MAX) begin
            tht_ctr_q[i] <= tht_ctr_q[i] + 2'h1;
          end else if (!ret_taken && tht_ctr_q[i] != CTR_MIN) begin
            tht_ctr_q[i] <= tht_ctr_q[i] - 2'h1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // return stack: speculative push/pop at fetch, checkpoint kept at retirement
  logic spec_push;
  logic spec_pop;
  logic arch_push;
  logic arch_pop;
  logic recover_now;
  // a mispredict retiring this cycle overrides any speculative push or pop
  assign recover_now = state_q == ST_RUN && ret_valid && ret_mispredict;
  assign spec_push = fetch_step && f_is_call && !recover_now;
  assign spec_pop = fetch_step && f_is_ret && ras_nonempty && !recover_now;
  assign arch_push = ret_valid && ret_kind == BK_CALL;
  assign arch_pop = ret_valid && ret_kind == BK_RET && ras_cnt_arch_q != RAS_CNT_RST;

  // call entries hold the next-instruction address; fetch uses the next word as an estimate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ras_top_q <= RAS_PTR_RST;
      ras_cnt_q <= RAS_CNT_RST;
    end else if (recover_now) begin
      ras_top_q <= arch_push ? ras_top_arch_q + 4'h1 : (arch_pop ? ras_top_arch_q - 4'h1 : ras_top_arch_q);
      ras_cnt_q <= arch_push ? ((ras_cnt_arch_q == RAS_CNT_MAX) ? RAS_CNT_MAX : ras_cnt_arch_q + 5'h01)
                             : (arch_pop ? ras_cnt_arch_q - 5'h01 : ras_cnt_arch_q);
    end else if (spec_push) begin
      // pointer wraps, so a seventeenth call overwrites the oldest slot
      ras_top_q <= ras_top_q + 4'h1;
      ras_cnt_q <= (ras_cnt_q == RAS_CNT_MAX) ? RAS_CNT_MAX : ras_cnt_q + 5'h01;
    end else if (spec_pop) begin
      ras_top_q <= ras_top_q - 4'h1;
      ras_cnt_q <= ras_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ras_top_arch_q <= RAS_PTR_RST;
      ras_cnt_arch_q <= RAS_CNT_RST;
    end else if (arch_push) begin
      ras_top_arch_q <= ras_top_arch_q + 4'h1;
      ras_cnt_arch_q <= (ras_cnt_arch_q == RAS_CNT_MAX) ? RAS_CNT_MAX : ras_cnt_arch_q + 5'h01;
    end else if (arch_pop) begin
      ras_top_arch_q <= ras_top_arch_q - 4'h1;
      ras_cnt_arch_q <= ras_cnt_arch_q - 5'h01;
    end
  end

  generate
    for (genvar j = 0; j < RAS_DEPTH; j++) begin : g_ras
      always_ff @(posedge core_clk) begin
        if (rst) begin
          ras_q[j] <= RESET_PC;
          ras_arch_q[j] <= RESET_PC;
        end else begin
          // limitation: the retiring call's length is taken from decode in the same cycle
          if (arch_push && ras_top_arch_q == RAS_PTR_W'(j)) begin
            ras_arch_q[j] <= ret_pc + 32'(dec_len);
          end
          if (recover_now) begin
            // restore speculative copy from the retired copy
            ras_q[j] <= (arch_push && ras_top_arch_q == RAS_PTR_W'(j)) ? ret_pc + 32'(dec_len) : ras_arch_q[j];
          end else if (spec_push && ras_top_q == RAS_PTR_W'(j)) begin
            ras_q[j] <= fetch_addr_q + 32'h4;
          end
        end
      end
    end
  endgenerate

endmodule

// [verif/bpu_fetch_model.sv]
// fetcher stand-in on the far side of the fetch handshake
// assumes the bench moves stall just after a rising edge of core_clk
`timescale 1ns/100ps
module bpu_fetch_model (
  // control from the bench
  input wire logic stall,
  // handshake toward the predictor
  output logic fetch_ready
);
  // ==========================================================================
  // ready is the inverse of stall so the bench can hold the chunk walk at will
  assign fetch_ready = !stall;
endmodule

// [verif/bpu_checker.sv]
// concurrent checks on the predictor's top-level ports
// assumes one core_clk domain and a synchronous active-high rst
`timescale 1ns/100ps
module bpu_checker
  import bpu_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // fetch side
  input wire logic fetch_ready,
  input wire logic fetch_valid_q,
  input wire logic [ADDR_W-1:0] fetch_addr_q,
  input wire logic fetch_pred_taken_q,
  input wire logic trace_continue_q,
  // decode side
  input wire logic dec_valid,
  input wire bpu_kind_t dec_kind,
  input wire logic [ADDR_W-1:0] dec_disp,
  input wire logic dec_pred_taken_q,
  input wire logic [ADDR_W-1:0] dec_pred_target_q,
  input wire logic dec_pred_static_q,
  // retirement side
  input wire logic ret_valid,
  input wire logic ret_mispredict,
  input wire logic recover_busy_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [5:0] busy_cnt_q;
  // ==========================================================================
  // busy length is counted here since 20 is past the repetition limit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_cnt_q <= 6'h00;
    end else begin
      busy_cnt_q <= recover_busy_q ? busy_cnt_q + 6'h01 : 6'h00;
    end
  end
  sequence s_plain_step;
    fetch_valid_q && fetch_ready && !recover_busy_q && !ret_valid ##1 !fetch_pred_taken_q;
  endsequence
  sequence s_new_miss;
    ret_valid && ret_mispredict && !recover_busy_q;
  endsequence
  // ==========================================================================
  a_chunk_step: assert property (s_plain_step |-> fetch_addr_q == ($past(fetch_addr_q) & ~32'h1f) + 32'h20)
    else $error("fetch did not advance to the next 32-byte chunk");
  a_stall_holds_addr: assert property (fetch_valid_q && !fetch_ready && !ret_valid |=> $stable(fetch_addr_q))
    else $error("fetch address moved while stalled");
  a_recover_entry: assert property (s_new_miss |=> !fetch_valid_q && recover_busy_q)
    else $error("misprediction did not stop fetch");
  a_recover_length: assert property ($fell(recover_busy_q) |-> busy_cnt_q == 6'h14 && fetch_valid_q)
    else $error("recovery length wrong");
  a_static_dir: assert property (dec_valid && dec_kind == BK_COND |=> !dec_pred_static_q || dec_pred_taken_q == $past(dec_disp[31]))
    else $error("static direction wrong");
  a_far_no_pred: assert property (dec_valid && dec_kind inside {BK_FAR, BK_NONE} |=> !dec_pred_taken_q && dec_pred_target_q == 32'h0 && !dec_pred_static_q)
    else $error("far transfer was predicted");
  a_ret_taken: assert property (dec_valid && dec_kind == BK_RET |=> dec_pred_taken_q)
    else $error("return not predicted taken");
  a_call_taken: assert property (dec_valid && dec_kind == BK_CALL |=> dec_pred_taken_q)
    else $error("call not predicted taken");
  a_trace_follows: assert property (trace_continue_q == fetch_pred_taken_q)
    else $error("trace continuation differs from taken flag");
  a_dec_clears: assert property (!dec_valid |=> !dec_pred_taken_q)
    else $error("decode prediction outlived its request");
endmodule
bind bpu_top bpu_checker bpu_checker_inst (.core_clk(core_clk), .rst(rst), .fetch_ready(fetch_ready),
  .fetch_valid_q(fetch_valid_q), .fetch_addr_q(fetch_addr_q), .fetch_pred_taken_q(fetch_pred_taken_q),
  .trace_continue_q(trace_continue_q), .dec_valid(dec_valid), .dec_kind(dec_kind), .dec_disp(dec_disp),
  .dec_pred_taken_q(dec_pred_taken_q), .dec_pred_target_q(dec_pred_target_q),
  .dec_pred_static_q(dec_pred_static_q), .ret_valid(ret_valid), .ret_mispredict(ret_mispredict),
  .recover_busy_q(recover_busy_q));

// [verif/bpu_top_tb_top.sv]
// self-checking bench for the branch predictor: fetch walk, static and table predictions, recovery
// assumes the fetch model on fetch_ready and the checker bound onto bpu_top
`timescale 1ns/100ps
module bpu_top_tb_top;
  import bpu_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, stall = 1'b1, fetch_ready;
  logic fetch_valid_q, fetch_pred_taken_q, trace_continue_q, recover_busy_q;
  logic [ADDR_W-1:0] fetch_addr_q, dec_pred_target_q;
  logic dec_pred_taken_q, dec_pred_static_q, dec_valid = 1'b0, ret_valid = 1'b0;
  logic ret_taken = 1'b0, ret_mispredict = 1'b0;
  logic [ADDR_W-1:0] dec_pc = 32'h0, dec_disp = 32'h0, ret_pc = 32'h0, ret_target = 32'h0;
  bpu_kind_t dec_kind = BK_NONE, ret_kind = BK_NONE;
  int miscompares = 0, num_checks = 0;
  always #25 core_clk = ~core_clk;
  bpu_fetch_model bpu_fetch_model_inst (.stall(stall), .fetch_ready(fetch_ready));
  bpu_top bpu_top_inst (.core_clk(core_clk), .rst(rst), .fetch_ready(fetch_ready), .fetch_valid_q(fetch_valid_q),
    .fetch_addr_q(fetch_addr_q), .fetch_pred_taken_q(fetch_pred_taken_q), .trace_continue_q(trace_continue_q),
    .dec_valid(dec_valid), .dec_pc(dec_pc), .dec_kind(dec_kind), .dec_disp(dec_disp), .dec_len(4'h5),
    .dec_pred_taken_q(dec_pred_taken_q), .dec_pred_target_q(dec_pred_target_q),
    .dec_pred_static_q(dec_pred_static_q), .ret_valid(ret_valid), .ret_pc(ret_pc), .ret_kind(ret_kind),
    .ret_taken(ret_taken), .ret_target(ret_target), .ret_mispredict(ret_mispredict),
    .recover_busy_q(recover_busy_q));
  // ==========================================================================
  // helpers: every drive lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    stall = 1'b1;
    tick(3);
    rst = 1'b0;
    chk(32'(fetch_valid_q), 32'h1);
    chk(fetch_addr_q, RESET_PC);
  endtask
  task automatic dec(input logic [31:0] pc, input bpu_kind_t k, input logic [31:0] disp);
    dec_pc = pc;
    dec_kind = k;
    dec_disp = disp;
    dec_valid = 1'b1;
    tick(1);
  endtask
  // valid stays up between back-to-back decodes; this drops it and sees the prediction clear
  task automatic dec_idle();
    dec_valid = 1'b0;
    tick(1);
    chk({dec_pred_taken_q, dec_pred_static_q}, 32'h0);
    chk(dec_pred_target_q, RESET_PC);
  endtask
  task automatic retire(input logic [31:0] pc, input bpu_kind_t k, input logic [31:0] tgt, input logic tk,
                        input logic mis);
    ret_pc = pc;
    ret_kind = k;
    ret_taken = tk;
    ret_target = tgt;
    ret_mispredict = mis;
    ret_valid = 1'b1;
    tick(1);
    ret_valid = 1'b0;
  endtask
  // counts the cycles recovery holds fetch off, n0 of them already seen by the caller
  task automatic wait_recover(input int n0, input logic [31:0] exp_addr);
    int n;
    n = n0;
    while (recover_busy_q === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(32'(n - 1), 32'(PIPE_DEPTH));
    chk(fetch_addr_q, exp_addr);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_static();
    do_reset();
    dec(32'h100, BK_COND, 32'hffff_fff0);
    chk({dec_pred_taken_q, dec_pred_static_q}, 32'h3);
    chk(dec_pred_target_q, 32'h0f0);
    dec(32'h100, BK_COND, 32'h10);
    chk({dec_pred_taken_q, dec_pred_static_q}, 32'h1);
    dec(32'h100, BK_FAR, 32'h10);
    chk({dec_pred_taken_q, dec_pred_static_q}, 32'h0);
    dec(32'h200, BK_CALL, 32'h40);
    chk(dec_pred_target_q, 32'h240);
    dec(32'h200, BK_IND, 32'h80);
    chk(dec_pred_target_q, 32'h280);
    dec(32'h300, BK_RET, 32'h0);
    chk(32'(dec_pred_taken_q), 32'h1);
    dec_idle();
  endtask
  // far retire and decode-time lookups must leave the table empty
  task automatic t_table();
    do_reset();
    dec(32'h0, BK_COND, 32'h40);
    retire(32'h0, BK_FAR, 32'h3000, 1'b1, 1'b0);
    stall = 1'b0;
    tick(1);
    chk(fetch_addr_q, 32'h20);
    stall = 1'b1;
    retire(32'h20, BK_COND, 32'h1000, 1'b1, 1'b0);
    stall = 1'b0;
    tick(1);
    chk(fetch_addr_q, 32'h1000);
    chk({fetch_pred_taken_q, trace_continue_q}, 32'h3);
    tick(1);
    chk(fetch_addr_q, 32'h1020);
    chk(32'(fetch_pred_taken_q), 32'h0);
    dec(32'h20, BK_COND, 32'h8);
    chk({dec_pred_taken_q, dec_pred_static_q}, 32'h2);
    chk(dec_pred_target_q, 32'h1000);
    dec_idle();
  endtask
  // a call hit pushes the next word; a return hit pops it back as the fetch target
  task automatic t_stack();
    do_reset();
    retire(32'h0, BK_CALL, 32'h400, 1'b1, 1'b0);
    stall = 1'b0;
    tick(1);
    stall = 1'b1;
    chk(fetch_addr_q, 32'h400);
    dec(32'h410, BK_RET, 32'h0);
    chk(dec_pred_target_q, 32'h4);
    retire(32'h400, BK_RET, 32'h900, 1'b1, 1'b0);
    stall = 1'b0;
    tick(1);
    stall = 1'b1;
    chk(fetch_addr_q, 32'h4);
    dec_idle();
  endtask
  task automatic t_recover();
    do_reset();
    retire(32'h300, BK_COND, 32'h2000, 1'b1, 1'b1);
    chk({recover_busy_q, fetch_valid_q}, 32'h2);
    wait_recover(1, 32'h2000);
    stall = 1'b0;
    tick(1);
    chk(fetch_addr_q, 32'h2020);
    // not-taken redirect; a second mispredict inside recovery must change nothing
    stall = 1'b1;
    retire(32'h300, BK_COND, 32'h2000, 1'b0, 1'b1);
    tick(1);
    retire(32'h340, BK_COND, 32'h5000, 1'b1, 1'b1);
    wait_recover(3, 32'h304);
  endtask
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_static();
    t_table();
    t_stack();
    t_recover();
    close_out();
  end
  // the whole run needs about 80 cycles; 2000 leaves ample margin
  initial begin
    repeat (2000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule
